// >>> pcoc_consts.svh
// register offsets, field positions, reset values and timing counts of the control bank
`ifndef PCOC_CONSTS_SVH
`define PCOC_CONSTS_SVH

`define PCOC_ADDR_W 8
`define PCOC_DATA_W 24
`define PCOC_FRAME_BITS 32
`define PCOC_OFS_READ_CTRL 8'h00
`define PCOC_OFS_MAIN_CONTROL_TWO 8'h23
`define PCOC_OFS_SPARE_A 8'h24
`define PCOC_OFS_SPARE_B 8'h25
`define PCOC_OFS_SPARE_C 8'h26
`define PCOC_OFS_FACTORY_A 8'h27
`define PCOC_OFS_FACTORY_B 8'h28
`define PCOC_OFS_ALARM_PIN_CONTROL 8'h29

`define PCOC_BIT_READ_EN 0
`define PCOC_BIT_TOPOLOGY 11
`define PCOC_BIT_HIZ 10
`define PCOC_BIT_XTAL_OFF 9
`define PCOC_BIT_MUST_ONE_HI 17
`define PCOC_BIT_MUST_ONE_LO 8
`define PCOC_BIT_TX_PD 2
`define PCOC_BIT_RX_PD 1
`define PCOC_BIT_FE_PD 0
`define PCOC_BIT_CLKMON_EN 7

`define PCOC_RESET_MAIN_CONTROL_TWO 24'h000000
`define PCOC_RESET_ALARM_PIN_CONTROL 24'h000000
`define PCOC_RESET_READ_CTRL 24'h000000
// arbitrary values, stand-ins for per-device factory content
`define PCOC_FACTORY_A_VALUE 24'h5A5A5A
`define PCOC_FACTORY_B_VALUE 24'hA5A5A5

// serial clock half period and system clock period in ns, and the half period in system clock cycles
`define PCOC_HALF_PERIOD_NS 40
`define PCOC_CLK_PERIOD_NS 5
`define PCOC_HALF_CYCLES (`PCOC_HALF_PERIOD_NS / `PCOC_CLK_PERIOD_NS)

`endif

// >>> pcoc_pkg.sv
// state type of the host end of the control bank link
package pcoc_pkg;
    typedef enum logic [1:0] {
        PCOC_HOST_IDLE = 2'b00,
        PCOC_HOST_SETUP = 2'b01,
        PCOC_HOST_SHIFT = 2'b10,
        PCOC_HOST_TAIL = 2'b11
    } pcoc_host_state_type;
endpackage

// >>> pcoc_spi_if.sv
// serial link between host and control bank
`timescale 1ns/1ps
interface pcoc_spi_if;
    logic sclk;
    logic ste_n;
    logic simo;
    logic somi;
    logic somi_oe;
    logic somi_wire;

    // pulled high when the device releases the line
    assign somi_wire = somi_oe ? somi : 1'b1;

    modport device (input sclk, input ste_n, input simo, output somi, output somi_oe);
    modport host (output sclk, output ste_n, output simo, input somi_wire);
endinterface

// >>> pcoc_device.sv
// device end: control register bank with serial slave and pin control
//
// Overview of operation
// - topology bit 0 H-bridge, 1 push-pull
// - high-impedance bit floats all digital outputs
// - device floats its return line when link idle
// - crystal-disable bit stops oscillator, external clock
// - transmit power-down bit stops transmitter only
// - receive power-down bit stops receiver only
// - front-end power-down stops transmitter, receiver, diagnostics
// - main control register resets to zero
// - host writes only zeros to spares
// - host ignores factory register contents
// - alarm register holds only bit 7
// - bit 7 routes internal clocks onto alarm pins
`timescale 1ns/1ps
`include "pcoc_consts.svh"

module pcoc_device
    import pcoc_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    pcoc_spi_if.device spi,
    input wire logic fault_pd_alarm_i,
    input wire logic fault_led_alarm_i,
    input wire logic [7:0] internal_clocks_i,
    input wire logic [2:0] clock_to_alarm_pin_select_i,
    input wire logic osc_clock_i,
    output logic led_driver_topology_sel_o,
    output logic output_hiz_sel_o,
    output logic crystal_osc_off_o,
    output logic tx_off_o,
    output logic rx_off_o,
    output logic diag_off_o,
    output logic photodiode_alarm_pin_o,
    output logic photodiode_alarm_pin_oe_o,
    output logic led_alarm_pin_o,
    output logic led_alarm_pin_oe_o,
    output logic clock_out_pin_o,
    output logic clock_out_pin_oe_o
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic sclk_s1, sclk_s2, sclk_s3;
    logic ste_s1, ste_s2;
    logic simo_s1, simo_s2;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
            ste_s1 <= 1'b1;
            ste_s2 <= 1'b1;
            simo_s1 <= 1'b0;
            simo_s2 <= 1'b0;
        end else begin
            sclk_s1 <= spi.sclk;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            ste_s1 <= spi.ste_n;
            ste_s2 <= ste_s1;
            simo_s1 <= spi.simo;
            simo_s2 <= simo_s1;
        end
    end

    logic frame_active;
    logic sclk_rise;
    logic sclk_fall;

    assign frame_active = ~ste_s2;
    assign sclk_rise = sclk_s2 & ~sclk_s3;
    assign sclk_fall = ~sclk_s2 & sclk_s3;

    ////////////////////////////////////////////////////////////////////////////
    // register storage
    logic read_en;
    logic topology;
    logic hiz;
    logic xtal_off;
    logic tx_pd;
    logic rx_pd;
    logic fe_pd;
    logic clkmon_en;

    function automatic logic [`PCOC_DATA_W-1:0] read_value(input logic [`PCOC_ADDR_W-1:0] addr);
        logic [`PCOC_DATA_W-1:0] value;
        value = '0;
        case (addr)
            `PCOC_OFS_READ_CTRL: begin
                value[`PCOC_BIT_READ_EN] = read_en;
            end
            `PCOC_OFS_MAIN_CONTROL_TWO: begin
                value[`PCOC_BIT_TOPOLOGY] = topology;
                value[`PCOC_BIT_HIZ] = hiz;
                value[`PCOC_BIT_XTAL_OFF] = xtal_off;
                value[`PCOC_BIT_TX_PD] = tx_pd;
                value[`PCOC_BIT_RX_PD] = rx_pd;
                value[`PCOC_BIT_FE_PD] = fe_pd;
            end
            `PCOC_OFS_FACTORY_A: begin
                value = `PCOC_FACTORY_A_VALUE;
            end
            `PCOC_OFS_FACTORY_B: begin
                value = `PCOC_FACTORY_B_VALUE;
            end
            `PCOC_OFS_ALARM_PIN_CONTROL: begin
                value[`PCOC_BIT_CLKMON_EN] = clkmon_en;
            end
            default: begin
                value = '0;
            end
        endcase
        return value;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // serial engine: 8 address bits then 24 data bits, msb first
    logic [5:0] bit_cnt, next_bit_cnt;
    logic [`PCOC_FRAME_BITS-1:0] shift_in, next_shift_in;
    logic [`PCOC_DATA_W-1:0] shift_out, next_shift_out;
    logic [`PCOC_ADDR_W-1:0] addr, next_addr;
    logic somi_oe, next_somi_oe;
    logic wr_strobe;
    logic [`PCOC_DATA_W-1:0] wr_data;

    always_comb begin
        next_bit_cnt = bit_cnt;
        next_shift_in = shift_in;
        next_shift_out = shift_out;
        next_addr = addr;
        wr_strobe = 1'b0;
        wr_data = {shift_in[`PCOC_DATA_W-2:0], simo_s2};
        if (!frame_active) begin
            next_bit_cnt = 6'h00;
        end else if (sclk_rise) begin
            next_shift_in = {shift_in[`PCOC_FRAME_BITS-2:0], simo_s2};
            next_bit_cnt = bit_cnt + 6'h01;
            if (bit_cnt == 6'(`PCOC_ADDR_W - 1)) begin
                next_addr = {shift_in[`PCOC_ADDR_W-2:0], simo_s2};
                next_shift_out = read_value({shift_in[`PCOC_ADDR_W-2:0], simo_s2});
            end
            // in read mode only the read control word stays writable
            if (bit_cnt == 6'(`PCOC_FRAME_BITS - 1)) begin
                wr_strobe = !read_en || (addr == `PCOC_OFS_READ_CTRL);
            end
        end else if (sclk_fall && bit_cnt >= 6'(`PCOC_ADDR_W + 1)) begin
            next_shift_out = {shift_out[`PCOC_DATA_W-2:0], 1'b0};
        end
        // return line floats outside reads and in high-impedance mode
        next_somi_oe = frame_active && read_en && !hiz && (next_bit_cnt >= 6'(`PCOC_ADDR_W));
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            bit_cnt <= 6'h00;
            shift_in <= '0;
            shift_out <= '0;
            addr <= '0;
            somi_oe <= 1'b0;
        end else begin
            bit_cnt <= next_bit_cnt;
            shift_in <= next_shift_in;
            shift_out <= next_shift_out;
            addr <= next_addr;
            somi_oe <= next_somi_oe;
        end
    end

    assign spi.somi = shift_out[`PCOC_DATA_W-1];
    assign spi.somi_oe = somi_oe;

    ////////////////////////////////////////////////////////////////////////////
    // register writes; spares and factory words keep no written data
    logic next_read_en, next_topology, next_hiz, next_xtal_off;
    logic next_tx_pd, next_rx_pd, next_fe_pd, next_clkmon_en;

    always_comb begin
        next_read_en = read_en;
        next_topology = topology;
        next_hiz = hiz;
        next_xtal_off = xtal_off;
        next_tx_pd = tx_pd;
        next_rx_pd = rx_pd;
        next_fe_pd = fe_pd;
        next_clkmon_en = clkmon_en;
        if (wr_strobe) begin
            case (addr)
                `PCOC_OFS_READ_CTRL: begin
                    next_read_en = wr_data[`PCOC_BIT_READ_EN];
                end
                `PCOC_OFS_MAIN_CONTROL_TWO: begin
                    next_topology = wr_data[`PCOC_BIT_TOPOLOGY];
                    next_hiz = wr_data[`PCOC_BIT_HIZ];
                    next_xtal_off = wr_data[`PCOC_BIT_XTAL_OFF];
                    next_tx_pd = wr_data[`PCOC_BIT_TX_PD];
                    next_rx_pd = wr_data[`PCOC_BIT_RX_PD];
                    next_fe_pd = wr_data[`PCOC_BIT_FE_PD];
                end
                `PCOC_OFS_ALARM_PIN_CONTROL: begin
                    next_clkmon_en = wr_data[`PCOC_BIT_CLKMON_EN];
                end
                default: begin
                    next_read_en = read_en;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            read_en <= 1'(`PCOC_RESET_READ_CTRL >> `PCOC_BIT_READ_EN);
            topology <= 1'(`PCOC_RESET_MAIN_CONTROL_TWO >> `PCOC_BIT_TOPOLOGY);
            hiz <= 1'(`PCOC_RESET_MAIN_CONTROL_TWO >> `PCOC_BIT_HIZ);
            xtal_off <= 1'(`PCOC_RESET_MAIN_CONTROL_TWO >> `PCOC_BIT_XTAL_OFF);
            tx_pd <= 1'(`PCOC_RESET_MAIN_CONTROL_TWO >> `PCOC_BIT_TX_PD);
            rx_pd <= 1'(`PCOC_RESET_MAIN_CONTROL_TWO >> `PCOC_BIT_RX_PD);
            fe_pd <= 1'(`PCOC_RESET_MAIN_CONTROL_TWO >> `PCOC_BIT_FE_PD);
            clkmon_en <= 1'(`PCOC_RESET_ALARM_PIN_CONTROL >> `PCOC_BIT_CLKMON_EN);
        end else begin
            read_en <= next_read_en;
            topology <= next_topology;
            hiz <= next_hiz;
            xtal_off <= next_xtal_off;
            tx_pd <= next_tx_pd;
            rx_pd <= next_rx_pd;
            fe_pd <= next_fe_pd;
            clkmon_en <= next_clkmon_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control outputs and pins
    logic next_pd_alarm, next_led_alarm, next_out_oe, next_clock_out;
    logic [2:0] led_sel;

    always_comb begin
        // second pin shows the neighbouring clock of the selection
        led_sel = clock_to_alarm_pin_select_i + 3'h1;
        if (clkmon_en) begin
            next_pd_alarm = internal_clocks_i[clock_to_alarm_pin_select_i];
            next_led_alarm = internal_clocks_i[led_sel];
        end else begin
            next_pd_alarm = fault_pd_alarm_i;
            next_led_alarm = fault_led_alarm_i;
        end
        next_out_oe = ~hiz;
        next_clock_out = osc_clock_i & ~xtal_off;
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            led_driver_topology_sel_o <= 1'b0;
            output_hiz_sel_o <= 1'b0;
            crystal_osc_off_o <= 1'b0;
            tx_off_o <= 1'b0;
            rx_off_o <= 1'b0;
            diag_off_o <= 1'b0;
            photodiode_alarm_pin_o <= 1'b0;
            photodiode_alarm_pin_oe_o <= 1'b0;
            led_alarm_pin_o <= 1'b0;
            led_alarm_pin_oe_o <= 1'b0;
            clock_out_pin_o <= 1'b0;
            clock_out_pin_oe_o <= 1'b0;
        end else begin
            led_driver_topology_sel_o <= topology;
            output_hiz_sel_o <= hiz;
            crystal_osc_off_o <= xtal_off;
            tx_off_o <= tx_pd | fe_pd;
            rx_off_o <= rx_pd | fe_pd;
            diag_off_o <= fe_pd;
            photodiode_alarm_pin_o <= next_pd_alarm;
            photodiode_alarm_pin_oe_o <= next_out_oe;
            led_alarm_pin_o <= next_led_alarm;
            led_alarm_pin_oe_o <= next_out_oe;
            clock_out_pin_o <= next_clock_out;
            clock_out_pin_oe_o <= next_out_oe;
        end
    end

endmodule // pcoc_device

// >>> pcoc_host.sv
// host end: serial master that reads and writes the control bank
`timescale 1ns/1ps
`include "pcoc_consts.svh"

module pcoc_host
    import pcoc_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    pcoc_spi_if.host spi,
    input wire logic start_i,
    input wire logic [7:0] addr_i,
    input wire logic [23:0] wdata_i,
    output logic busy_o,
    output logic done_o,
    output logic refused_o,
    output logic [23:0] rdata_o,
    output logic ext_clock_needed_o,
    output logic device_hiz_o
);

    ////////////////////////////////////////////////////////////////////////////
    // return line synchroniser and half period divider
    logic somi_s1, somi_s2;
    logic [3:0] div_cnt;
    logic tick;

    assign tick = (div_cnt == 4'(`PCOC_HALF_CYCLES - 1));

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            somi_s1 <= 1'b1;
            somi_s2 <= 1'b1;
            div_cnt <= 4'h0;
        end else begin
            somi_s1 <= spi.somi_wire;
            somi_s2 <= somi_s1;
            div_cnt <= tick ? 4'h0 : div_cnt + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame sequencer
    pcoc_host_state_type state, next_state;
    logic [5:0] bit_cnt, next_bit_cnt;
    logic [31:0] tx, next_tx;
    logic [23:0] rx, next_rx;
    logic sclk, next_sclk, ste_n, next_ste_n;
    logic busy, next_busy, done, next_done, refused, next_refused;
    logic [23:0] rdata, next_rdata;
    logic ext_clk, next_ext_clk, hiz_shadow, next_hiz_shadow;
    logic read_mode, next_read_mode;
    logic is_spare, is_factory;

    always_comb begin
        is_spare = (addr_i >= `PCOC_OFS_SPARE_A) && (addr_i <= `PCOC_OFS_SPARE_C);
        is_factory = (addr_i == `PCOC_OFS_FACTORY_A) || (addr_i == `PCOC_OFS_FACTORY_B);
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_tx = tx;
        next_rx = rx;
        next_sclk = sclk;
        next_ste_n = ste_n;
        next_busy = busy;
        next_done = 1'b0;
        next_refused = 1'b0;
        next_rdata = rdata;
        next_ext_clk = ext_clk;
        next_hiz_shadow = hiz_shadow;
        next_read_mode = read_mode;
        case (state)
            PCOC_HOST_IDLE: begin
                if (start_i && is_factory) begin
                    next_refused = 1'b1;
                end else if (start_i) begin
                    next_tx = {addr_i, is_spare ? 24'h000000 : wdata_i};
                    if (addr_i == `PCOC_OFS_READ_CTRL) begin
                        next_read_mode = wdata_i[`PCOC_BIT_READ_EN];
                    end
                    // in read mode the device keeps the control word, so the shadows stay
                    if (addr_i == `PCOC_OFS_MAIN_CONTROL_TWO && !read_mode) begin
                        next_ext_clk = wdata_i[`PCOC_BIT_XTAL_OFF];
                        next_hiz_shadow = wdata_i[`PCOC_BIT_HIZ];
                    end
                    next_busy = 1'b1;
                    next_bit_cnt = 6'h00;
                    next_state = PCOC_HOST_SETUP;
                end
            end
            PCOC_HOST_SETUP: begin
                if (tick) begin
                    next_ste_n = 1'b0;
                    next_state = PCOC_HOST_SHIFT;
                end
            end
            PCOC_HOST_SHIFT: begin
                if (tick && !sclk) begin
                    next_sclk = 1'b1;
                end else if (tick) begin
                    next_sclk = 1'b0;
                    next_rx = {rx[22:0], somi_s2};
                    next_tx = {tx[30:0], 1'b0};
                    next_bit_cnt = bit_cnt + 6'h01;
                    if (bit_cnt == 6'(`PCOC_FRAME_BITS - 1)) begin
                        next_state = PCOC_HOST_TAIL;
                    end
                end
            end
            PCOC_HOST_TAIL: begin
                if (tick) begin
                    next_ste_n = 1'b1;
                    next_busy = 1'b0;
                    next_done = 1'b1;
                    next_rdata = rx;
                    next_state = PCOC_HOST_IDLE;
                end
            end
            default: begin
                next_state = PCOC_HOST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= PCOC_HOST_IDLE;
            bit_cnt <= 6'h00;
            tx <= 32'h00000000;
            rx <= 24'h000000;
            sclk <= 1'b0;
            ste_n <= 1'b1;
            busy <= 1'b0;
            done <= 1'b0;
            refused <= 1'b0;
            rdata <= 24'h000000;
            ext_clk <= 1'b0;
            hiz_shadow <= 1'b0;
            read_mode <= 1'(`PCOC_RESET_READ_CTRL >> `PCOC_BIT_READ_EN);
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            tx <= next_tx;
            rx <= next_rx;
            sclk <= next_sclk;
            ste_n <= next_ste_n;
            busy <= next_busy;
            done <= next_done;
            refused <= next_refused;
            rdata <= next_rdata;
            ext_clk <= next_ext_clk;
            hiz_shadow <= next_hiz_shadow;
            read_mode <= next_read_mode;
        end
    end

    assign spi.sclk = sclk;
    assign spi.ste_n = ste_n;
    assign spi.simo = tx[31];
    assign busy_o = busy;
    assign done_o = done;
    assign refused_o = refused;
    assign rdata_o = rdata;
    assign ext_clock_needed_o = ext_clk;
    assign device_hiz_o = hiz_shadow;

endmodule // pcoc_host

// >>> pcoc_link_props_props.sv
// concurrent checks on the serial link and pin controls of the control bank
`timescale 1ns/1ps
module pcoc_link_props (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic sclk,
    input wire logic ste_n,
    input wire logic somi_oe,
    input wire logic led_driver_topology_sel_o,
    input wire logic output_hiz_sel_o,
    input wire logic crystal_osc_off_o,
    input wire logic tx_off_o,
    input wire logic rx_off_o,
    input wire logic diag_off_o,
    input wire logic photodiode_alarm_pin_oe_o,
    input wire logic led_alarm_pin_oe_o,
    input wire logic clock_out_pin_o,
    input wire logic clock_out_pin_oe_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    logic [5:0] cfg;
    logic all_oe;
    logic no_oe;
    assign cfg = {led_driver_topology_sel_o, output_hiz_sel_o, crystal_osc_off_o, tx_off_o, rx_off_o, diag_off_o};
    assign all_oe = photodiode_alarm_pin_oe_o && led_alarm_pin_oe_o && clock_out_pin_oe_o;
    assign no_oe = !photodiode_alarm_pin_oe_o && !led_alarm_pin_oe_o && !clock_out_pin_oe_o;

    ////////////////////////////////////////
    sequence hiz_held;
        output_hiz_sel_o [*2];
    endsequence
    sequence hiz_clear;
        (!output_hiz_sel_o) [*3];
    endsequence
    sequence link_quiet;
        ste_n [*6];
    endsequence

    ////////////////////////////////////////
    chk_hiz_floats_pins: assert property (hiz_held |-> no_oe && !somi_oe)
        else $error("digital output driven in high impedance mode");
    chk_normal_pins_drive: assert property (hiz_clear |-> all_oe)
        else $error("digital output not driven in normal mode");
    chk_somi_link_release: assert property (link_quiet |-> !somi_oe)
        else $error("serial output driven outside a frame");
    chk_frontend_covers_all: assert property (diag_off_o |-> tx_off_o && rx_off_o)
        else $error("front end down but a module still powered");
    chk_reset_clears_cfg: assert property ($fell(reset_i) |-> cfg == 6'h00 ##1 cfg == 6'h00)
        else $error("control outputs not zero after reset");
    chk_cfg_frame_only: assert property ($changed(cfg) |-> !ste_n)
        else $error("control output changed outside a frame");
    chk_osc_gate_off: assert property (crystal_osc_off_o [*2] |-> !clock_out_pin_o)
        else $error("clock output runs with oscillator off");
    chk_sclk_idle_low: assert property (ste_n [*2] |-> !sclk)
        else $error("serial clock not idle low between frames");
endmodule // pcoc_link_props

// >>> tb.sv
// self-checking bench: host and control bank joined over the serial link
`timescale 1ns/1ps
module tb;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic start_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [23:0] wdata_i = 24'h000000;
    logic fault_pd = 1'b0;
    logic fault_led = 1'b0;
    logic osc = 1'b0;
    logic [7:0] iclk = 8'h00;
    logic [2:0] sel = 3'h0;
    logic topo, hiz, xoff, txo, rxo, dgo, pd_pin, pd_oe, led_pin, led_oe, ck_pin, ck_oe;
    logic busy, done, refused, ext_clk, dev_hiz;
    logic [23:0] rdata;
    logic [23:0] last_rdata;
    logic last_refused;
    integer seed = 32'h726E22CA;
    int errors = 0;
    int total_checks = 0;
    logic [23:0] corner [6] = '{24'h000800, 24'h000200, 24'h000004, 24'h000002, 24'h000001, 24'h000A07};

    pcoc_spi_if link();
    pcoc_host u_pcoc_host (.clk_i(clk_i), .reset_i(reset_i), .spi(link.host), .start_i(start_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .busy_o(busy), .done_o(done), .refused_o(refused), .rdata_o(rdata),
        .ext_clock_needed_o(ext_clk), .device_hiz_o(dev_hiz));
    pcoc_device u_pcoc_device (.clk_i(clk_i), .reset_i(reset_i), .spi(link.device), .fault_pd_alarm_i(fault_pd),
        .fault_led_alarm_i(fault_led), .internal_clocks_i(iclk), .clock_to_alarm_pin_select_i(sel),
        .osc_clock_i(osc), .led_driver_topology_sel_o(topo), .output_hiz_sel_o(hiz), .crystal_osc_off_o(xoff),
        .tx_off_o(txo), .rx_off_o(rxo), .diag_off_o(dgo), .photodiode_alarm_pin_o(pd_pin),
        .photodiode_alarm_pin_oe_o(pd_oe), .led_alarm_pin_o(led_pin), .led_alarm_pin_oe_o(led_oe),
        .clock_out_pin_o(ck_pin), .clock_out_pin_oe_o(ck_oe));
    pcoc_link_props u_props (.clk_i(clk_i), .reset_i(reset_i), .sclk(link.sclk), .ste_n(link.ste_n),
        .somi_oe(link.somi_oe), .led_driver_topology_sel_o(topo), .output_hiz_sel_o(hiz),
        .crystal_osc_off_o(xoff), .tx_off_o(txo), .rx_off_o(rxo), .diag_off_o(dgo),
        .photodiode_alarm_pin_oe_o(pd_oe), .led_alarm_pin_oe_o(led_oe), .clock_out_pin_o(ck_pin),
        .clock_out_pin_oe_o(ck_oe));

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        osc <= ~osc;
    end

    ////////////////////////////////////////
    function automatic logic [23:0] exp_main(input logic [23:0] d);
        return d & 24'h000E07;
    endfunction

    function automatic logic [23:0] exp_alarm(input logic [23:0] d);
        return d & 24'h000080;
    endfunction

    task automatic check_word(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one host request, waits for done or refusal
    task automatic xfer(input logic [7:0] a, input logic [23:0] d);
        logic seen;
        logic busy_seen;
        seen = 1'b0;
        busy_seen = 1'b0;
        @(posedge clk_i);
        start_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        start_i <= 1'b0;
        repeat (700) begin
            @(negedge clk_i);
            busy_seen = busy_seen | (busy === 1'b1);
            if (done === 1'b1 || refused === 1'b1) begin
                seen = 1'b1;
                break;
            end
        end
        last_refused = refused;
        last_rdata = rdata;
        check_bit(seen, 1'b1);
        check_bit(busy_seen, !last_refused);
        check_bit(busy, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, output logic [23:0] v);
        logic [31:0] r;
        r = $random(seed);
        xfer(8'h00, 24'h000001);
        xfer(a, r[23:0]);
        v = last_rdata;
        xfer(8'h00, 24'h000000);
    endtask

    task automatic check_cfg(input logic [23:0] d);
        check_bit(topo, d[11]);
        check_bit(hiz, d[10]);
        check_bit(xoff, d[9]);
        check_bit(txo, d[2] | d[0]);
        check_bit(rxo, d[1] | d[0]);
        check_bit(dgo, d[0]);
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge clk_i);
        errors++;
        complete_run;
    end

    initial begin
        logic [23:0] v;
        logic [23:0] d;
        logic [31:0] r;
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        @(negedge clk_i);
        check_cfg(24'h000000);
        rd(8'h23, v);
        check_word(v, 24'h000000);
        // corners first, then legal random settings; must-be-one bits added
        for (int i = 0; i < 10; i++) begin
            r = $random(seed);
            d = (i < 6) ? corner[i] : (r[23:0] & 24'h000A07);
            xfer(8'h23, d | 24'h020100);
            check_cfg(d);
            check_bit(ext_clk, d[9]);
            check_bit(dev_hiz, d[10]);
            rd(8'h23, v);
            check_word(v, exp_main(d | 24'h020100));
        end
        xfer(8'h23, 24'h020500);
        check_cfg(24'h000400);
        check_bit(dev_hiz, 1'b1);
        rd(8'h23, v);
        check_word(v, 24'hFFFFFF);
        check_bit(dev_hiz, 1'b1);
        xfer(8'h23, 24'h020100);
        check_bit(ck_oe, 1'b1);
        for (int i = 0; i < 3; i++) begin
            r = $random(seed);
            xfer(8'h24 + i[7:0], r[23:0]);
            rd(8'h24 + i[7:0], v);
            check_word(v, 24'h000000);
        end
        for (int i = 0; i < 2; i++) begin
            xfer(8'h27 + i[7:0], 24'h000000);
            check_bit(last_refused, 1'b1);
        end
        xfer(8'h29, 24'h000080);
        rd(8'h29, v);
        check_word(v, exp_alarm(24'h000080));
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            @(posedge clk_i);
            iclk <= r[7:0];
            sel <= i[2:0];
            fault_pd <= r[8];
            fault_led <= r[9];
            repeat (3) @(negedge clk_i);
            check_bit(pd_pin, r[i]);
            check_bit(led_pin, r[(i + 1) % 8]);
        end
        xfer(8'h29, 24'h000000);
        rd(8'h29, v);
        check_word(v, exp_alarm(24'h000000));
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            @(posedge clk_i);
            fault_pd <= r[0];
            fault_led <= r[1];
            repeat (3) @(negedge clk_i);
            check_bit(pd_pin, r[0]);
            check_bit(led_pin, r[1]);
        end
        // second reset after setting every control bit except high impedance
        xfer(8'h23, 24'h020A07);
        @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        @(negedge clk_i);
        check_cfg(24'h000000);
        rd(8'h23, v);
        check_word(v, 24'h000000);
        complete_run;
    end
endmodule // tb
